// ### rtl/sbs_pkg.sv
// constants and pin bundle layout for the burst-of-four sram pair
// assumes one 100 mhz reference clock feeding both ends
package sbs_pkg;

   // ==========================================================
   // widths and burst shape
   localparam int ADDR_W = 18;
   localparam int WORD_W = 18;
   localparam int MEM_AW = 20;
   localparam int LANE_W = 9;
   localparam int N_LANES = 2;
   localparam int N_WORDS = 4;
   localparam logic [2:0] BURST_LEN = 3'h4;
   localparam logic [1:0] LAST_IDX = 2'h3;
   localparam logic [1:0] MID_IDX = 2'h2;
   localparam logic [1:0] FIRST_IDX = 2'h0;

   // ==========================================================
   // timing counts in reference clock cycles
   localparam logic [9:0] IMP_LAST = 10'h3ff;     // update every 1024 cycles
   localparam logic [2:0] STRAP_LAST = 3'h3;      // strap sampled on this count
   localparam logic [2:0] STRAP_DONE = 3'h4;
   localparam logic [3:0] STRAP_HOLD = 4'h8;      // strobes quiet while the strap is taken

   // ==========================================================
   // controller phase of one strobe period (four reference cycles)
   localparam logic [1:0] PH_TRUE = 2'h0;         // true strobe rises here
   localparam logic [1:0] PH_TRUE_HI = 2'h1;
   localparam logic [1:0] PH_INV = 2'h2;          // inverse strobe rises here
   localparam logic [1:0] PH_INV_HI = 2'h3;

   // ==========================================================
   // pin bundle as seen by the device input registers
   typedef struct packed {
      logic k;
      logic kb;
      logic c;
      logic cb;
      logic rsel_n;
      logic wsel_n;
      logic [N_LANES-1:0] lane_sel_n;
      logic [ADDR_W-1:0] addr;
      logic [WORD_W-1:0] d;
   } sbs_pin_s;

endpackage : sbs_pkg

// ### rtl/sbs_if.sv
// pin bundle between the memory controller end and the sram end
// assumes both ends run from the same reference clock
`timescale 1ns/1ps
interface sbs_if;
   import sbs_pkg::*;

   // ==========================================================
   // strobes
   logic input_strobe_true;
   logic input_strobe_inverse;
   logic output_strobe_true;
   logic output_strobe_inverse;
   // ==========================================================
   // control, address, data
   logic read_port_select_n;
   logic write_port_select_n;
   logic [N_LANES-1:0] byte_write_select_n;
   logic [ADDR_W-1:0] addr_bus;
   logic [WORD_W-1:0] write_bus_in;
   logic [WORD_W-1:0] read_bus_out;
   logic read_bus_oe;        // high while the sram drives read_bus_out

   modport dev (
      input input_strobe_true, input_strobe_inverse,
      input output_strobe_true, output_strobe_inverse,
      input read_port_select_n, write_port_select_n, byte_write_select_n,
      input addr_bus, write_bus_in,
      output read_bus_out, read_bus_oe
   );

   modport ctl (
      output input_strobe_true, input_strobe_inverse,
      output output_strobe_true, output_strobe_inverse,
      output read_port_select_n, write_port_select_n, byte_write_select_n,
      output addr_bus, write_bus_in,
      input read_bus_out, read_bus_oe
   );

endinterface : sbs_if

// ### rtl/sbs_ctl.sv
// memory controller end: makes all strobes and issues bursts
// assumes user holds a request with its address and data until acked
`timescale 1ns/1ps
module sbs_ctl (
   // clock, reset, enable
   input logic I_REF_CLK,
   input logic I_NRST,
   input logic I_CE,
   // static strap choice
   input logic I_SINGLE_CLK,
   // read request
   input logic I_RD_REQ,
   input logic [sbs_pkg::ADDR_W-1:0] I_RD_ADDR,
   output logic O_RD_ACK,
   output logic [4*sbs_pkg::WORD_W-1:0] O_RD_DATA,
   output logic O_RD_VALID,
   // write request
   input logic I_WR_REQ,
   input logic [sbs_pkg::ADDR_W-1:0] I_WR_ADDR,
   input logic [4*sbs_pkg::WORD_W-1:0] I_WR_DATA,
   input logic [4*sbs_pkg::N_LANES-1:0] I_WR_BE_N,
   output logic O_WR_ACK,
   // sram pins
   sbs_if.ctl PIN
);
   import sbs_pkg::*;

   logic [3:0] hold_r;
   logic [1:0] ph_r;
   logic run;
   logic k_r, kb_r, c_r, cb_r;
   logic rsel_n_r, wsel_n_r;
   logic [N_LANES-1:0] lane_sel_n_r;
   logic [ADDR_W-1:0] addr_r;
   logic [WORD_W-1:0] d_r;
   logic rd_prev_r, wr_prev_r;
   logic rd_go, wr_go;
   logic [4*WORD_W-1:0] wstage_r, wsh_r;
   logic [4*N_LANES-1:0] bstage_r, bsh_r;
   logic [1:0] wleft_r;
   logic [WORD_W-1:0] q_s1_r, q_s2_r;
   logic oe_s1_r, oe_s2_r;
   logic [1:0] qcnt_r;
   logic [4*WORD_W-1:0] rbuf_r;
   logic rd_ack_r, wr_ack_r, rd_val_r;

   assign run = (hold_r == STRAP_HOLD);
   // one start per true rise; never the same port twice in a row
   assign rd_go = run && (ph_r == PH_INV) && I_RD_REQ && !rd_prev_r;
   assign wr_go = run && (ph_r == PH_INV) && I_WR_REQ && !wr_prev_r && !rd_go;

   // ==========================================================
   // strobe generation: divider of the reference clock
   always_ff @(posedge I_REF_CLK) begin
      if (!I_NRST) begin
         hold_r <= '0;
         ph_r <= PH_INV_HI;
         k_r <= 1'b0;
         kb_r <= 1'b0;
         // output strobes carry the strap level; high only for single-clock mode
         c_r <= I_SINGLE_CLK;
         cb_r <= I_SINGLE_CLK;
      end else if (I_CE) begin
         if (!run) begin
            hold_r <= hold_r + 4'h1;  // strobes quiet while the strap settles
         end else begin
            ph_r <= ph_r + 2'h1;
            k_r <= (ph_r == PH_INV_HI) || (ph_r == PH_TRUE);
            kb_r <= (ph_r == PH_TRUE_HI) || (ph_r == PH_INV);
            // zero skew output strobes, or both high for single-clock mode
            c_r <= I_SINGLE_CLK || (ph_r == PH_INV_HI) || (ph_r == PH_TRUE);
            cb_r <= I_SINGLE_CLK || (ph_r == PH_TRUE_HI) || (ph_r == PH_INV);
         end
      end
   end

   // ==========================================================
   // command and write data launch, one phase before each strobe rise
   always_ff @(posedge I_REF_CLK) begin
      if (!I_NRST) begin
         rsel_n_r <= 1'b1;
         wsel_n_r <= 1'b1;
         lane_sel_n_r <= '1;
         addr_r <= '0;
         d_r <= '0;
         rd_prev_r <= 1'b0;
         wr_prev_r <= 1'b0;
         wleft_r <= '0;
         wstage_r <= '0;
         bstage_r <= '1;
         wsh_r <= '0;
         bsh_r <= '1;
         rd_ack_r <= 1'b0;
         wr_ack_r <= 1'b0;
      end else if (I_CE) begin
         rd_ack_r <= rd_go;
         wr_ack_r <= wr_go;
         if (run && ph_r == PH_INV) begin
            rsel_n_r <= !rd_go;
            wsel_n_r <= !wr_go;
            addr_r <= rd_go ? I_RD_ADDR : I_WR_ADDR;
            rd_prev_r <= rd_go;
            wr_prev_r <= wr_go;
            if (wr_go) begin
               wstage_r <= I_WR_DATA;
               bstage_r <= I_WR_BE_N;
            end
            // data follows one true rise after the write start
            if (wr_prev_r) begin
               d_r <= wstage_r[WORD_W-1:0];
               lane_sel_n_r <= bstage_r[N_LANES-1:0];
               wsh_r <= wstage_r >> WORD_W;
               bsh_r <= bstage_r >> N_LANES;
               wleft_r <= LAST_IDX;
            end else if (wleft_r != 2'h0) begin
               d_r <= wsh_r[WORD_W-1:0];
               lane_sel_n_r <= bsh_r[N_LANES-1:0];
               wsh_r <= wsh_r >> WORD_W;
               bsh_r <= bsh_r >> N_LANES;
               wleft_r <= wleft_r - 2'h1;
            end else begin
               lane_sel_n_r <= '1;
            end
         end else if (run && ph_r == PH_TRUE) begin
            if (wleft_r != 2'h0) begin
               d_r <= wsh_r[WORD_W-1:0];
               lane_sel_n_r <= bsh_r[N_LANES-1:0];
               wsh_r <= wsh_r >> WORD_W;
               bsh_r <= bsh_r >> N_LANES;
               wleft_r <= wleft_r - 2'h1;
            end else begin
               lane_sel_n_r <= '1;
            end
         end
      end
   end

   // ==========================================================
   // read capture: pins pass two flops, then sample mid-word
   always_ff @(posedge I_REF_CLK) begin
      if (!I_NRST) begin
         q_s1_r <= '0;
         q_s2_r <= '0;
         oe_s1_r <= 1'b0;
         oe_s2_r <= 1'b0;
         qcnt_r <= '0;
         rbuf_r <= '0;
         rd_val_r <= 1'b0;
      end else if (I_CE) begin
         q_s1_r <= PIN.read_bus_out;
         q_s2_r <= q_s1_r;
         oe_s1_r <= PIN.read_bus_oe;
         oe_s2_r <= oe_s1_r;
         rd_val_r <= 1'b0;
         if (run && oe_s2_r && (ph_r == PH_INV || ph_r == PH_TRUE)) begin
            // lowest word arrives first and lands in the low bits
            rbuf_r <= {q_s2_r, rbuf_r[4*WORD_W-1:WORD_W]};
            qcnt_r <= qcnt_r + 2'h1;
            rd_val_r <= (qcnt_r == LAST_IDX);
         end
      end
   end

   assign PIN.input_strobe_true = k_r;
   assign PIN.input_strobe_inverse = kb_r;
   assign PIN.output_strobe_true = c_r;
   assign PIN.output_strobe_inverse = cb_r;
   assign PIN.read_port_select_n = rsel_n_r;
   assign PIN.write_port_select_n = wsel_n_r;
   assign PIN.byte_write_select_n = lane_sel_n_r;
   assign PIN.addr_bus = addr_r;
   assign PIN.write_bus_in = d_r;
   assign O_RD_ACK = rd_ack_r;
   assign O_WR_ACK = wr_ack_r;
   assign O_RD_DATA = rbuf_r;
   assign O_RD_VALID = rd_val_r;

endmodule : sbs_ctl

// ### rtl/sbs_dev.sv
// sram end: separate read and write ports, burst of four, ddr strobes
// assumes strobes arrive from the controller as pins of the reference
// clock domain; every pin passes two flops before use
`timescale 1ns/1ps
module sbs_dev (
   // clock, reset, enable
   input logic I_REF_CLK,
   input logic I_NRST,
   input logic I_CE,
   // sram pins
   sbs_if.dev PIN,
   // status
   output logic O_IMPEDANCE_UPDATE
);
   import sbs_pkg::*;

   // ==========================================================
   // declarations
   sbs_pin_s pin_now;
   sbs_pin_s s1_r;
   sbs_pin_s s2_r;
   logic [3:0] stb_d_r;
   logic k_rise, kb_rise, c_rise, cb_rise;
   logic oc_rise, ocb_rise;
   logic [2:0] strap_cnt_r;
   logic single_r;
   logic live;
   logic rd_prev_r, wr_prev_r;
   logic rd_go, wr_go;
   logic rd_arm_r, wr_arm_r;
   logic [ADDR_W-1:0] rd_addr_r, wr_addr_r;
   logic [ADDR_W-1:0] out_addr_r;
   logic [1:0] out_idx_r;
   logic [2:0] out_left_r;
   logic load_now, have_word;
   logic [ADDR_W-1:0] src_addr;
   logic [1:0] src_idx;
   logic [WORD_W-1:0] rd_word;
   logic [WORD_W-1:0] q_r;
   logic oe_r;
   logic col_on_r;
   logic [1:0] col_idx_r;
   logic [ADDR_W-1:0] col_addr_r;
   logic [WORD_W-1:0] wdat_r [0:N_WORDS-1];
   logic [N_LANES-1:0] wen_r [0:N_WORDS-1];
   logic [N_WORDS-1:0] wval_r;
   logic commit_r;
   logic [9:0] imp_cnt_r;
   logic imp_r;
   logic [WORD_W-1:0] mem [0:(1 << MEM_AW)-1];

   // byte lanes: enable bit n covers bits n*9 .. n*9+8
   function automatic logic [WORD_W-1:0] lane_merge(
      input logic [WORD_W-1:0] old_w,
      input logic [WORD_W-1:0] new_w,
      input logic [N_LANES-1:0] en);
      logic [WORD_W-1:0] m;
      m = {{LANE_W{en[1]}}, {LANE_W{en[0]}}};
      return (new_w & m) | (old_w & ~m);
   endfunction : lane_merge

   // ==========================================================
   // input registers: two flops on every pin
   assign pin_now = '{k: PIN.input_strobe_true, kb: PIN.input_strobe_inverse,
                      c: PIN.output_strobe_true, cb: PIN.output_strobe_inverse,
                      rsel_n: PIN.read_port_select_n,
                      wsel_n: PIN.write_port_select_n,
                      lane_sel_n: PIN.byte_write_select_n,
                      addr: PIN.addr_bus, d: PIN.write_bus_in};

   always_ff @(posedge I_REF_CLK) begin
      if (!I_NRST) begin
         s1_r <= '0;
         s2_r <= '0;
         stb_d_r <= '0;
      end else if (I_CE) begin
         s1_r <= pin_now;
         s2_r <= s1_r;
         stb_d_r <= {s2_r.k, s2_r.kb, s2_r.c, s2_r.cb};
      end
   end

   // strobe rises, only after the strap has been taken
   assign live = (strap_cnt_r == STRAP_DONE);
   assign k_rise = live && s2_r.k && !stb_d_r[3];
   assign kb_rise = live && s2_r.kb && !stb_d_r[2];
   assign c_rise = live && s2_r.c && !stb_d_r[1];
   assign cb_rise = live && s2_r.cb && !stb_d_r[0];
   assign oc_rise = single_r ? k_rise : c_rise;
   assign ocb_rise = single_r ? kb_rise : cb_rise;

   // ==========================================================
   // strap: caught once after reset release, fixed afterwards
   always_ff @(posedge I_REF_CLK) begin
      if (!I_NRST) begin
         strap_cnt_r <= '0;
         single_r <= 1'b0;
      end else if (I_CE && !live) begin
         strap_cnt_r <= strap_cnt_r + 3'h1;
         if (strap_cnt_r == STRAP_LAST) begin
            single_r <= s2_r.c && s2_r.cb;
         end
      end
   end

   // ==========================================================
   // start arbitration: selects looked at on true rise only
   // a port that started last rise cannot start again, so the other wins
   assign rd_go = k_rise && !s2_r.rsel_n && !rd_prev_r;
   assign wr_go = k_rise && !s2_r.wsel_n && !wr_prev_r && !rd_go;

   always_ff @(posedge I_REF_CLK) begin
      if (!I_NRST) begin
         rd_prev_r <= 1'b0;
         wr_prev_r <= 1'b0;
         rd_arm_r <= 1'b0;
         wr_arm_r <= 1'b0;
         rd_addr_r <= '0;
         wr_addr_r <= '0;
      end else if (I_CE && k_rise) begin
         rd_prev_r <= rd_go;
         wr_prev_r <= wr_go;
         rd_arm_r <= rd_go;
         wr_arm_r <= wr_go;
         if (rd_go) begin
            rd_addr_r <= s2_r.addr;
         end
         if (wr_go) begin
            wr_addr_r <= s2_r.addr;
         end
      end
   end

   // ==========================================================
   // read word source, with forwarding from the write data register
   assign load_now = k_rise && rd_arm_r;
   assign have_word = load_now || (out_left_r != 3'h0);
   assign src_addr = load_now ? rd_addr_r : out_addr_r;
   assign src_idx = load_now ? FIRST_IDX : out_idx_r;

   always_comb begin
      rd_word = mem[{src_addr, src_idx}];
      // a write not yet committed still holds the newest bytes
      if (wval_r[src_idx] && (col_addr_r == src_addr)) begin
         rd_word = lane_merge(rd_word, wdat_r[src_idx], wen_r[src_idx]);
      end
   end

   // ==========================================================
   // output register: one word per output strobe rise
   // a burst, once loaded, always runs out its four words
   always_ff @(posedge I_REF_CLK) begin
      if (!I_NRST) begin
         q_r <= '0;
         oe_r <= 1'b0;
         out_addr_r <= '0;
         out_idx_r <= '0;
         out_left_r <= '0;
      end else if (I_CE) begin
         if ((oc_rise || ocb_rise) && have_word) begin
            q_r <= rd_word;
            oe_r <= 1'b1;
            out_idx_r <= src_idx + 2'h1;
            out_left_r <= (load_now ? BURST_LEN : out_left_r) - 3'h1;
            if (load_now) begin
               out_addr_r <= rd_addr_r;
            end
         end else if (load_now) begin
            out_addr_r <= rd_addr_r;
            out_idx_r <= FIRST_IDX;
            out_left_r <= BURST_LEN;
         end else if (oc_rise) begin
            oe_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // write data register: four words, lanes sampled with each word
   always_ff @(posedge I_REF_CLK) begin
      if (!I_NRST) begin
         col_on_r <= 1'b0;
         col_idx_r <= '0;
         col_addr_r <= '0;
         wval_r <= '0;
         commit_r <= 1'b0;
      end else if (I_CE) begin
         commit_r <= 1'b0;
         if (commit_r) begin
            wval_r <= '0;
         end
         if (k_rise && wr_arm_r) begin
            col_addr_r <= wr_addr_r;
            col_on_r <= 1'b1;
            col_idx_r <= 2'h1;
            wval_r <= 4'h1;
         end else if (col_on_r && (k_rise || kb_rise)) begin
            wval_r[col_idx_r] <= 1'b1;
            col_idx_r <= col_idx_r + 2'h1;
            if (col_idx_r == LAST_IDX) begin
               col_on_r <= 1'b0;
               commit_r <= 1'b1;
            end
         end
      end
   end

   // word and lane capture, one entry per burst position
   for (genvar w = 0; w < N_WORDS; w++) begin : g_wdat
      always_ff @(posedge I_REF_CLK) begin
         if (!I_NRST) begin
            wdat_r[w] <= '0;
            wen_r[w] <= '0;
         end else if (I_CE) begin
            if ((k_rise && wr_arm_r && w == 0) ||
                (col_on_r && (k_rise || kb_rise) && col_idx_r == 2'(w))) begin
               wdat_r[w] <= s2_r.d;
               wen_r[w] <= ~s2_r.lane_sel_n;
            end
         end
      end
   end

   // ==========================================================
   // array commit: all four words at once, masked per lane
   always_ff @(posedge I_REF_CLK) begin
      if (I_CE && commit_r) begin
         for (int w = 0; w < N_WORDS; w++) begin
            mem[{col_addr_r, 2'(w)}] <=
               lane_merge(mem[{col_addr_r, 2'(w)}], wdat_r[w], wen_r[w]);
         end
      end
   end

   // ==========================================================
   // driver impedance update tick; free running from reset release
   always_ff @(posedge I_REF_CLK) begin
      if (!I_NRST) begin
         imp_cnt_r <= '0;
         imp_r <= 1'b0;
      end else if (I_CE) begin
         imp_cnt_r <= imp_cnt_r + 10'h1;
         imp_r <= (imp_cnt_r == IMP_LAST);
      end
   end

   assign PIN.read_bus_out = q_r;
   assign PIN.read_bus_oe = oe_r;
   assign O_IMPEDANCE_UPDATE = imp_r;

endmodule : sbs_dev

// ### sim/sbs_chk.sv
// checker for the pin bundle between controller and sram ends
// assumes it sits beside the interface, fed by plain signal copies
`timescale 1ns/1ps
module sbs_chk (
   // clock and reset
   input wire logic I_REF_CLK,
   input wire logic I_NRST,
   // strobes and selects
   input wire logic input_strobe_true,
   input wire logic input_strobe_inverse,
   input wire logic read_port_select_n,
   input wire logic write_port_select_n,
   // read side and status
   input wire logic [sbs_pkg::WORD_W-1:0] read_bus_out,
   input wire logic read_bus_oe,
   input wire logic O_IMPEDANCE_UPDATE
);
   import sbs_pkg::*;
   logic [4:0] rd_age_r;
   logic [9:0] imp_gap_r;
   logic imp_seen_r;
   default clocking cb @(posedge I_REF_CLK); endclocking
   default disable iff (!I_NRST);
   // ==========================================================
   // start events
   sequence rd_start_s;
      $rose(input_strobe_true) && !read_port_select_n;
   endsequence
   sequence wr_start_s;
      $rose(input_strobe_true) && !write_port_select_n;
   endsequence
   // cycles since the last read start, saturating so idle stays idle
   always_ff @(posedge I_REF_CLK) begin
      if (!I_NRST) rd_age_r <= 5'h1f;
      else if ($rose(input_strobe_true) && !read_port_select_n) rd_age_r <= 5'h00;
      else if (rd_age_r != 5'h1f) rd_age_r <= rd_age_r + 5'h01;
   end
   // gap between update pulses; first pulse only arms the check
   always_ff @(posedge I_REF_CLK) begin
      if (!I_NRST) imp_gap_r <= 10'h000;
      else if (O_IMPEDANCE_UPDATE) imp_gap_r <= 10'h000;
      else imp_gap_r <= imp_gap_r + 10'h001;
   end
   always_ff @(posedge I_REF_CLK) begin
      if (!I_NRST) imp_seen_r <= 1'b0;
      else if (O_IMPEDANCE_UPDATE) imp_seen_r <= 1'b1;
   end
   // ==========================================================
   // properties
   rd_word_a: assert property (rd_start_s |-> ##[6:8] read_bus_oe)
      else $error("read burst late");
   rd_four_a: assert property ($rose(read_bus_oe) |-> read_bus_oe[*8])
      else $error("read burst short");
   word_hold_a: assert property (read_bus_oe && $changed(read_bus_out) |=>
      $stable(read_bus_out)) else $error("read word held under two cycles");
   rd_float_a: assert property (rd_age_r > 5'h18 |-> !read_bus_oe)
      else $error("read bus driven while idle");
   rd_space_a: assert property (rd_start_s |=>
      (!($rose(input_strobe_true) && !read_port_select_n))[*4])
      else $error("reads on consecutive rises");
   wr_space_a: assert property (wr_start_s |=>
      (!($rose(input_strobe_true) && !write_port_select_n))[*4])
      else $error("writes on consecutive rises");
   strobe_order_a: assert property ($rose(input_strobe_true) |-> ##2
      $rose(input_strobe_inverse) ##2 $rose(input_strobe_true))
      else $error("strobe order broken");
   imp_period_a: assert property (imp_seen_r |->
      (O_IMPEDANCE_UPDATE == (imp_gap_r == IMP_LAST)))
      else $error("impedance update period wrong");
endmodule : sbs_chk

// ### sim/tb_separate_io_burst4_sram.sv
// self-checking bench: controller end facing the sram end
// assumes a free-running 100 mhz clock and no other traffic
`timescale 1ns/1ps
module tb_separate_io_burst4_sram;
   import sbs_pkg::*;
   localparam logic [71:0] D1 = 72'h0123456789abcdef01;
   localparam logic [71:0] D2 = 72'hfedcba9876543210fe;
   logic ref_clk, rst_n, ce, single_clk, rd_req, rd_ack, rd_valid;
   logic wr_req, wr_ack, imp_upd;
   logic [ADDR_W-1:0] rd_addr, wr_addr;
   logic [4*WORD_W-1:0] rd_data, wr_data;
   logic [4*N_LANES-1:0] wr_be_n;
   logic [WORD_W-1:0] first_w;
   int num_errors = 0;
   int comparisons = 0;
   sbs_if u_sbs_if ();
   sbs_ctl u_sbs_ctl (.I_REF_CLK(ref_clk), .I_NRST(rst_n), .I_CE(ce),
      .I_SINGLE_CLK(single_clk), .I_RD_REQ(rd_req), .I_RD_ADDR(rd_addr),
      .O_RD_ACK(rd_ack), .O_RD_DATA(rd_data), .O_RD_VALID(rd_valid),
      .I_WR_REQ(wr_req), .I_WR_ADDR(wr_addr), .I_WR_DATA(wr_data),
      .I_WR_BE_N(wr_be_n), .O_WR_ACK(wr_ack), .PIN(u_sbs_if));
   sbs_dev u_sbs_dev (.I_REF_CLK(ref_clk), .I_NRST(rst_n), .I_CE(ce),
      .PIN(u_sbs_if), .O_IMPEDANCE_UPDATE(imp_upd));
   sbs_chk u_sbs_chk (.I_REF_CLK(ref_clk), .I_NRST(rst_n),
      .input_strobe_true(u_sbs_if.input_strobe_true),
      .input_strobe_inverse(u_sbs_if.input_strobe_inverse),
      .read_port_select_n(u_sbs_if.read_port_select_n),
      .write_port_select_n(u_sbs_if.write_port_select_n),
      .read_bus_out(u_sbs_if.read_bus_out), .read_bus_oe(u_sbs_if.read_bus_oe),
      .O_IMPEDANCE_UPDATE(imp_upd));
   // ==========================================================
   // helpers
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask : tick
   task automatic check(input logic [71:0] seen, input logic [71:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   function automatic logic flag(input int w);
      return w == 0 ? wr_ack : w == 1 ? rd_ack : w == 2 ? rd_valid : u_sbs_if.read_bus_oe;
   endfunction : flag
   // bounded wait; a hang counts as a mismatch
   task automatic wait_on(input int w);
      int n;
      n = 0;
      do begin
         tick();
         n++;
      end while (flag(w) !== 1'b1 && n < 200);
      if (n >= 200) num_errors++;
   endtask : wait_on
   task automatic wr(input logic [17:0] a, input logic [71:0] d, input logic [7:0] m);
      wr_addr = a;
      wr_data = d;
      wr_be_n = m;
      wr_req = 1'b1;
      wait_on(0);
      wr_req = 1'b0;
      tick(); // a following call must not raise the request in the same step
   endtask : wr
   // first word is taken off the wire as it appears
   task automatic rd(input logic [17:0] a, output logic [71:0] q);
      rd_addr = a;
      rd_req = 1'b1;
      wait_on(1);
      rd_req = 1'b0;
      wait_on(3);
      first_w = u_sbs_if.read_bus_out;
      wait_on(2);
      q = rd_data;
   endtask : rd
   task automatic do_reset(input logic sc);
      rst_n = 1'b0;
      single_clk = sc;
      repeat (4) tick();
      rst_n = 1'b1;
   endtask : do_reset
   // ==========================================================
   // scenarios
   // forwarded read right behind a write, then committed neighbours
   task automatic t_burst();
      logic [71:0] q;
      wr(18'h00010, D1, 8'h00);
      rd(18'h00010, q);
      check(q, D1);
      check(first_w, D1[17:0]);
      check(u_sbs_dev.single_r, 1'b0);
      wr(18'h00011, D2, 8'h00);
      repeat (20) tick();
      rd(18'h00010, q);
      check(q, D1);
      rd(18'h00011, q);
      check(q, D2);
   endtask : t_burst
   // lane masks differ per word over an all-ones background
   task automatic t_mask();
      logic [71:0] q;
      wr(18'h00020, {72{1'b1}}, 8'h00);
      wr(18'h00020, 72'h0, 8'h6c);
      repeat (20) tick();
      rd(18'h00020, q);
      check(q, {18'h001ff, 18'h3fe00, 18'h3ffff, 18'h00000});
   endtask : t_mask
   // both ports requested from idle: read wins, sees the old data
   task automatic t_both();
      logic [71:0] q;
      logic rfirst;
      int n;
      wr(18'h00030, D1, 8'h00);
      repeat (20) tick();
      rd_addr = 18'h00030;
      wr_data = D2;
      rd_req = 1'b1;
      wr_req = 1'b1;
      rfirst = 1'b0;
      n = 0;
      while ((rd_req || wr_req) && n < 200) begin
         tick();
         n++;
         if (rd_ack === 1'b1) begin
            rd_req = 1'b0;
            rfirst = wr_req;
         end
         if (wr_ack === 1'b1) wr_req = 1'b0;
      end
      wait_on(2);
      check(rfirst, 1'b1);
      check(rd_data, D1);
      rd(18'h00030, q);
      check(q, D2);
   endtask : t_both
   // strap taken at reset; outputs timed by the input strobes
   task automatic t_single();
      logic [71:0] q;
      do_reset(1'b1);
      wr(18'h00040, D2, 8'h00);
      repeat (20) tick();
      rd(18'h00040, q);
      check(q, D2);
      check(first_w, D2[17:0]);
      check(u_sbs_dev.single_r, 1'b1);
   endtask : t_single
   // ==========================================================
   // verdict, clock, watchdog, main sequence
   task automatic test_done();
      if (num_errors == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : test_done
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   initial begin
      #100000;
      num_errors++;
      test_done();
   end
   initial begin
      ce = 1'b1;
      rd_req = 1'b0;
      wr_req = 1'b0;
      rd_addr = '0;
      wr_addr = '0;
      wr_data = '0;
      wr_be_n = '1;
      do_reset(1'b0);
      t_burst();
      t_mask();
      t_both();
      repeat (2100) tick(); // lets two impedance pulses pass
      t_single();
      test_done();
   end
endmodule : tb_separate_io_burst4_sram
